// >>> core/spd_pkg.sv
// shared constants, types and tables of the step pulse decoder
// What this block does
// - two-line mode: clockwise line release steps clockwise
// - two-line mode: counter line release steps counter-clockwise
// - one-line mode, sense on: step pulse clockwise
// - one-line mode, sense off: step pulse counter-clockwise
// - controller never pulses both lines together
// - controller parks optocoupled lines non-conducting
// - logic variant steps on rising pulse edge
// - logic pulses at least 1 us, duty half
// - logic lines park high while stopped
// - windings-off asserted removes all winding current
// - windings-off released restores current and torque
// - controller never cuts windings while moving
// - wait 0.1 s after release before stepping
// - step select picks secondary or primary dial
// - four-bit code selects division of basic step
// - resolution changes only stopped and at home
// - home output on at excitation step zero
// - excitation state starts at home after reset
// - home recurs every 7.2 degrees of rotation
// - controller waits 10 us on sense change
// - standstill current 0.1 s after pulses stop
// - mode selector picks two-line or one-line
// - dials give 16 positions, same division table
package spd_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_WIDTH_NS = 1000;
  localparam int SETTLE_NS     = 10000;
  localparam int RESTART_MS    = 100;
  localparam int STANDSTILL_MS = 100;

  localparam int STEP_WIDTH_CYC =
    (STEP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_CYC = RESTART_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STANDSTILL_CYC = STANDSTILL_MS * 1000000 / CLK_PERIOD_NS;

  localparam int TIMER_W = 24;
  localparam int PULSE_W = 16;
  localparam int POS_W   = 12;
  localparam int COUNT_W = 16;

  // synchronised pin vector layout
  localparam int PIN_A     = 0;
  localparam int PIN_B     = 1;
  localparam int PIN_WOFF  = 2;
  localparam int PIN_SEL   = 3;
  localparam int PIN_CODE  = 4;
  localparam int PIN_DIAL1 = 8;
  localparam int PIN_DIAL2 = 12;
  localparam int PIN_CHECK = 16;
  localparam int PIN_W     = 17;

  // controller register map and fields
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_MOVE   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_WOFF  = 0;
  localparam int CTRL_SEL   = 1;
  localparam int CTRL_CODE  = 4;
  localparam int MOVE_CW    = 16;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_GAP    = 2'b11
  } spd_pulse_state_t;

  // microsteps per 7.2 degrees: ten basic steps times the division
  function automatic logic [POS_W-1:0] spd_home_period(
    input logic [3:0] code
  );
    case (code)
      4'h0: spd_home_period = 12'h00A;
      4'h1: spd_home_period = 12'h014;
      4'h2: spd_home_period = 12'h019;
      4'h3: spd_home_period = 12'h028;
      4'h4: spd_home_period = 12'h032;
      4'h5: spd_home_period = 12'h050;
      4'h6: spd_home_period = 12'h064;
      4'h7: spd_home_period = 12'h0C8;
      4'h8: spd_home_period = 12'h0FA;
      4'h9: spd_home_period = 12'h190;
      4'hA: spd_home_period = 12'h1F4;
      4'hB: spd_home_period = 12'h320;
      4'hC: spd_home_period = 12'h3E8;
      4'hD: spd_home_period = 12'h4E2;
      4'hE: spd_home_period = 12'h7D0;
      default: spd_home_period = 12'h9C4;
    endcase
  endfunction

endpackage

// >>> core/spd_link_if.sv
// pin-level link between step controller and driver
`timescale 1ns/1ns
interface spd_link_if;
  logic       lineA;
  logic       lineB;
  logic       windingsOff;
  logic       stepSelect;
  logic [3:0] resCode;
  logic       home;

  modport driver (
    input  lineA,
    input  lineB,
    input  windingsOff,
    input  stepSelect,
    input  resCode,
    output home
  );

  modport controller (
    output lineA,
    output lineB,
    output windingsOff,
    output stepSelect,
    output resCode,
    input  home
  );
endinterface

// >>> core/spd_driver.sv
// driver end: pulse decoding, excitation position and home output
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
module spd_driver
  import spd_pkg::*;
#(
  parameter bit LOGIC_LEVEL       = 1'b0,
  parameter int STANDSTILL_CYCLES = STANDSTILL_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  spd_link_if.driver            link,
  input  wire logic             modeTwoLine,
  input  wire logic [3:0]       dialPrimary,
  input  wire logic [3:0]       dialSecondary,
  input  wire logic             currentCheck,
  output logic                  microStep,
  output logic                  microCw,
  output logic                  windingsEnabled,
  output logic                  standstill,
  output logic [POS_W-1:0]      excitationPos,
  output logic [3:0]            divisionCode,
  output logic                  twoLineActive
);

  // level of a pulse line at rest: high on the logic variant
  localparam logic IDLE_LVL = LOGIC_LEVEL;
  localparam logic [PIN_W-1:0] PIN_RESET =
    {{(PIN_W-2){1'b0}}, IDLE_LVL, IDLE_LVL};

  logic [PIN_W-1:0]   pinRaw;
  logic [PIN_W-1:0]   sync1_reg;
  logic [PIN_W-1:0]   sync2_reg;
  logic [PIN_W-1:0]   sync3_reg;
  logic [PIN_W-1:0]   pin_reg;
  logic [PIN_W-1:0]   pin_next;
  logic               prevA_reg;
  logic               prevB_reg;
  logic               strapDone_reg;
  logic               doneA;
  logic               doneB;
  logic               stepReq;
  logic               stepCw;
  logic [3:0]         code;
  logic [POS_W-1:0]   period;
  logic [POS_W-1:0]   pos_next;
  logic [TIMER_W-1:0] quiet_reg;
  logic               linesIdle;

  assign pinRaw = {currentCheck, dialSecondary, dialPrimary, link.resCode,
                   link.stepSelect, link.windingsOff, link.lineB,
                   link.lineA};

  // a bit changes once the second and third stages agree
  assign pin_next = (sync2_reg & sync3_reg) |
                    (pin_reg & (sync2_reg ^ sync3_reg));

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= PIN_RESET;
      sync2_reg <= PIN_RESET;
      sync3_reg <= PIN_RESET;
      pin_reg   <= PIN_RESET;
    end else begin
      sync1_reg <= pinRaw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= pin_next;
    end
  end

  // mode switch is only moved with power off, so it is caught once
  always_ff @(posedge mclk) begin
    if (rst) begin
      strapDone_reg <= 1'b0;
      twoLineActive <= 1'b1;
    end else if (!strapDone_reg) begin
      strapDone_reg <= 1'b1;
      twoLineActive <= modeTwoLine;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prevA_reg <= IDLE_LVL;
      prevB_reg <= IDLE_LVL;
    end else begin
      prevA_reg <= pin_reg[PIN_A];
      prevB_reg <= pin_reg[PIN_B];
    end
  end

  // step counts when a line returns from active to rest:
  // conducting to off on the optocoupled variant, low to high on logic
  assign doneA = (prevA_reg != IDLE_LVL) && (pin_reg[PIN_A] == IDLE_LVL);
  assign doneB = (prevB_reg != IDLE_LVL) && (pin_reg[PIN_B] == IDLE_LVL);

  always_comb begin
    stepReq = 1'b0;
    stepCw  = 1'b1;
    if (twoLineActive) begin
      // both at once is undefined; take neither
      if (doneA && !doneB) begin
        stepReq = 1'b1;
        stepCw  = 1'b1;
      end else if (doneB && !doneA) begin
        stepReq = 1'b1;
        stepCw  = 1'b0;
      end
    end else if (doneA) begin
      stepReq = 1'b1;
      // sense line on (conducting or high) means clockwise
      stepCw = pin_reg[PIN_B];
    end
  end

  always_comb begin
    if (LOGIC_LEVEL) begin
      code = pin_reg[PIN_CODE +: 4];
    end else if (pin_reg[PIN_SEL]) begin
      code = pin_reg[PIN_DIAL2 +: 4];
    end else begin
      code = pin_reg[PIN_DIAL1 +: 4];
    end
  end

  assign period = spd_home_period(code);

  // position wraps modulo one home period; a stale value past the
  // period after a resolution change folds back on the next step
  always_comb begin
    pos_next = excitationPos;
    if (stepReq && !pin_reg[PIN_WOFF]) begin
      if (stepCw) begin
        if (excitationPos >= period - 12'h001) begin
          pos_next = '0;
        end else begin
          pos_next = excitationPos + 12'h001;
        end
      end else begin
        if (excitationPos == '0 || excitationPos >= period) begin
          pos_next = period - 12'h001;
        end else begin
          pos_next = excitationPos - 12'h001;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      excitationPos <= '0;
    end else begin
      excitationPos <= pos_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      link.home <= 1'b1;
    end else begin
      link.home <= (pos_next == '0);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      microStep <= 1'b0;
      microCw   <= 1'b1;
    end else begin
      microStep <= stepReq && !pin_reg[PIN_WOFF];
      if (stepReq) begin
        microCw <= stepCw;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      windingsEnabled <= 1'b1;
    end else if (pin_reg[PIN_WOFF]) begin
      windingsEnabled <= 1'b0;
    end else begin
      windingsEnabled <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      divisionCode <= 4'h0;
    end else begin
      divisionCode <= code;
    end
  end

  // a pulse line left at its active level holds run current
  assign linesIdle = (pin_reg[PIN_A] == IDLE_LVL) &&
                     (!twoLineActive || pin_reg[PIN_B] == IDLE_LVL);

  always_ff @(posedge mclk) begin
    if (rst) begin
      quiet_reg <= '0;
    end else if (stepReq) begin
      quiet_reg <= '0;
    end else if (quiet_reg < TIMER_W'(STANDSTILL_CYCLES)) begin
      quiet_reg <= quiet_reg + 24'h000001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      standstill <= 1'b0;
    end else begin
      standstill <= !pin_reg[PIN_CHECK] && linesIdle &&
                    (quiet_reg >= TIMER_W'(STANDSTILL_CYCLES));
    end
  end

endmodule

// >>> core/spd_controller.sv
// controller end: Wishbone-ordered step pulse generator
`timescale 1ns/1ns
module spd_controller
  import spd_pkg::*;
#(
  parameter bit LOGIC_LEVEL    = 1'b0,
  parameter bit TWO_LINE       = 1'b1,
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  spd_link_if.controller   link
);

  localparam logic IDLE_LVL = LOGIC_LEVEL;

  spd_pulse_state_t   state_reg;
  logic [7:0]         ctrl_reg;
  logic [COUNT_W-1:0] remain_reg;
  logic               moveCw_reg;
  logic               lastCw_reg;
  logic [PULSE_W-1:0] tmr_reg;
  logic [TIMER_W-1:0] restart_reg;
  logic [2:0]         homeSync_reg;
  logic               home_reg;
  logic               acc;
  logic               wr;
  logic               busy;
  logic               canStart;
  logic               resPending;

  assign acc  = cyc_i && stb_i && !ack_o;
  // writes land on the edge that sees ack high
  assign wr   = cyc_i && stb_i && we_i && ack_o;
  assign busy = (remain_reg != '0) || (state_reg != ST_IDLE);
  assign canStart = !link.windingsOff && (restart_reg == '0);
  assign resPending = (link.resCode != ctrl_reg[CTRL_CODE +: 4]) ||
                      (link.stepSelect != ctrl_reg[CTRL_SEL]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      homeSync_reg <= 3'h0;
      home_reg     <= 1'b0;
    end else begin
      homeSync_reg <= {homeSync_reg[1:0], link.home};
      if (homeSync_reg[1] == homeSync_reg[2]) begin
        home_reg <= homeSync_reg[2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr && adr_i == REG_CTRL && sel_i[0]) begin
      ctrl_reg <= dat_i[7:0];
    end
  end

  // windings cut and resolution follow the settings only when stopped
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.windingsOff <= 1'b0;
      link.stepSelect  <= 1'b0;
      link.resCode     <= 4'h0;
    end else if (!busy) begin
      link.windingsOff <= ctrl_reg[CTRL_WOFF];
      if (home_reg) begin
        link.stepSelect <= ctrl_reg[CTRL_SEL];
        link.resCode    <= ctrl_reg[CTRL_CODE +: 4];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      restart_reg <= '0;
    end else if (link.windingsOff && !busy && !ctrl_reg[CTRL_WOFF]) begin
      restart_reg <= TIMER_W'(RESTART_CYCLES);
    end else if (restart_reg != '0) begin
      restart_reg <= restart_reg - 24'h000001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      remain_reg <= '0;
      moveCw_reg <= 1'b1;
    end else if (wr && adr_i == REG_MOVE && sel_i == 4'hF && !busy) begin
      remain_reg <= dat_i[COUNT_W-1:0];
      moveCw_reg <= dat_i[MOVE_CW];
    end else if (state_reg == ST_GAP && tmr_reg == '0) begin
      remain_reg <= remain_reg - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      tmr_reg    <= '0;
      lastCw_reg <= 1'b1;
      link.lineA <= IDLE_LVL;
      link.lineB <= TWO_LINE ? IDLE_LVL : 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (remain_reg != '0 && canStart) begin
            lastCw_reg <= moveCw_reg;
            if (moveCw_reg != lastCw_reg) begin
              state_reg <= ST_SETTLE;
              tmr_reg   <= PULSE_W'(SETTLE_CYC - 1);
              if (!TWO_LINE) begin
                link.lineB <= moveCw_reg;
              end
            end else begin
              state_reg <= ST_ACTIVE;
              tmr_reg   <= PULSE_W'(STEP_WIDTH_CYC - 1);
              if (TWO_LINE && !moveCw_reg) begin
                link.lineB <= !IDLE_LVL;
              end else begin
                link.lineA <= !IDLE_LVL;
              end
            end
          end
        end
        ST_SETTLE: begin
          if (tmr_reg == '0) begin
            state_reg <= ST_ACTIVE;
            tmr_reg   <= PULSE_W'(STEP_WIDTH_CYC - 1);
            if (TWO_LINE && !lastCw_reg) begin
              link.lineB <= !IDLE_LVL;
            end else begin
              link.lineA <= !IDLE_LVL;
            end
          end else begin
            tmr_reg <= tmr_reg - 16'h0001;
          end
        end
        ST_ACTIVE: begin
          if (tmr_reg == '0) begin
            // gap as long as the pulse keeps the duty at half or less
            state_reg  <= ST_GAP;
            tmr_reg    <= PULSE_W'(STEP_WIDTH_CYC - 1);
            link.lineA <= IDLE_LVL;
            if (TWO_LINE) begin
              link.lineB <= IDLE_LVL;
            end
          end else begin
            tmr_reg <= tmr_reg - 16'h0001;
          end
        end
        ST_GAP: begin
          if (tmr_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            tmr_reg <= tmr_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= acc;
      if (acc && !we_i) begin
        case (adr_i)
          REG_CTRL: dat_o <= {24'h000000, ctrl_reg};
          REG_MOVE: dat_o <= {15'h0000, moveCw_reg, remain_reg};
          REG_STATUS: dat_o <= {27'h0000000, (restart_reg != '0),
                                resPending, link.windingsOff,
                                home_reg, busy};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> testbench/spd_link_sva.sv
// checker of pulse spacing, idle levels and home timing on the link
`timescale 1ns/1ns
module spd_link_sva
  import spd_pkg::*;
#(
  parameter bit LOGIC_LEVEL    = 1'b0,
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       lineA,
  input wire logic       lineB,
  input wire logic       windingsOff,
  input wire logic       stepSelect,
  input wire logic [3:0] resCode,
  input wire logic       home
);
  logic        actA;
  logic        actB;
  logic        act;
  logic        lastA_reg;
  logic [7:0]  widthCnt_reg;
  logic [15:0] gapCnt_reg;
  logic [23:0] offCnt_reg;

  assign actA = lineA != LOGIC_LEVEL;
  assign actB = lineB != LOGIC_LEVEL;
  assign act  = actA | actB;

  // counters saturate; reset counts as a long idle
  always_ff @(posedge mclk) begin
    if (rst || !act) widthCnt_reg <= 8'h00;
    else if (widthCnt_reg != 8'hFF) widthCnt_reg <= widthCnt_reg + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (rst) gapCnt_reg <= 16'hFFFF;
    else if (act) gapCnt_reg <= 16'h0000;
    else if (gapCnt_reg != 16'hFFFF) gapCnt_reg <= gapCnt_reg + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (rst) offCnt_reg <= 24'hFFFFFF;
    else if (windingsOff) offCnt_reg <= 24'h000000;
    else if (offCnt_reg != 24'hFFFFFF) offCnt_reg <= offCnt_reg + 24'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst || actA) lastA_reg <= 1'b1;
    else if (actB) lastA_reg <= 1'b0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_one_line; !(actA && actB); endproperty
  a_one_line: assert property (p_one_line)
    else $error("both pulse lines active");
  property p_width; $fell(act) |-> widthCnt_reg >= STEP_WIDTH_CYC; endproperty
  a_width: assert property (p_width)
    else $error("pulse too short");
  property p_duty; $rose(act) |-> gapCnt_reg >= STEP_WIDTH_CYC; endproperty
  a_duty: assert property (p_duty)
    else $error("idle gap shorter than pulse");
  property p_off_idle; windingsOff |-> !act; endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("pulse while windings off");
  property p_restart; $rose(act) |-> offCnt_reg + 1 >= RESTART_CYCLES;
  endproperty
  a_restart: assert property (p_restart)
    else $error("pulse too soon after windings on");
  property p_turn;
    ($rose(actA) && !lastA_reg) || ($rose(actB) && lastA_reg)
      |-> gapCnt_reg >= SETTLE_CYC;
  endproperty
  a_turn: assert property (p_turn)
    else $error("direction change without settle time");
  property p_res_home;
    $changed(stepSelect) || $changed(resCode) |-> $past(home) && !act;
  endproperty
  a_res_home: assert property (p_res_home)
    else $error("resolution changed away from home");
  property p_home_reset; $fell(rst) |-> home; endproperty
  a_home_reset: assert property (p_home_reset)
    else $error("home off after reset");
  property p_home_step; $changed(home) |-> gapCnt_reg inside {[4:8]};
  endproperty
  a_home_step: assert property (p_home_step)
    else $error("home moved without a step");
  property p_park; $fell(act) |-> !act [*8]; endproperty
  a_park: assert property (p_park)
    else $error("pulse line left its rest level");
endmodule

// >>> testbench/test_stepper_pulse_input_decoder.sv
// bench: both link ends, wishbone orders, step and home checks
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    nErrors++; \
    $display("ERROR %0t got %h want %h", $time, got, exp); \
  end \
end
module test_stepper_pulse_input_decoder;
  import spd_pkg::*;
  localparam int RESTART = 20;
  localparam int DIV10[3] = '{10, 20, 25};
  localparam int QUIET = 50;
  logic        mclk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW;
  logic [31:0] datR;
  logic        ack;
  logic [31:0] rdat;
  logic [3:0]  dialP;
  logic [3:0]  dialS;
  logic        curChk;
  logic        microStep;
  logic        microCw;
  logic        windEn;
  logic        standstill;
  logic [11:0] pos;
  logic [11:0] pos2;
  logic [3:0]  divCode;
  logic        twoLine;
  logic        twoLine2;
  logic        modeTwo;
  logic        modeOne;
  logic [3:0]  divCode2;
  logic [12:0] note;
  logic [12:0] expQ[$];
  int          nErrors = 0;
  int          totalChecks = 0;
  int          expPos;
  int          expPer;
  int          seed;
  int          r;
  int          c;

  spd_link_if link();
  spd_link_if link2();
  spd_controller #(.TWO_LINE(1'b1), .RESTART_CYCLES(RESTART))
    spd_controller_i (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
    .ack_o(ack), .link(link));
  spd_driver #(.STANDSTILL_CYCLES(QUIET)) spd_driver_i (.mclk(mclk),
    .rst(rst), .link(link), .modeTwoLine(modeTwo), .dialPrimary(dialP),
    .dialSecondary(dialS), .currentCheck(curChk), .microStep(microStep),
    .microCw(microCw), .windingsEnabled(windEn), .standstill(standstill),
    .excitationPos(pos), .divisionCode(divCode), .twoLineActive(twoLine));
  // one-line logic-level pair fed by the same bus orders
  spd_controller #(.LOGIC_LEVEL(1'b1), .TWO_LINE(1'b0),
    .RESTART_CYCLES(RESTART))
    spd_controller_1p_i (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(),
    .ack_o(), .link(link2));
  spd_driver #(.LOGIC_LEVEL(1'b1), .STANDSTILL_CYCLES(QUIET))
    spd_driver_1p_i (.mclk(mclk),
    .rst(rst), .link(link2), .modeTwoLine(modeOne), .dialPrimary(dialP),
    .dialSecondary(dialS), .currentCheck(curChk), .microStep(),
    .microCw(), .windingsEnabled(), .standstill(), .excitationPos(pos2),
    .divisionCode(divCode2), .twoLineActive(twoLine2));
  spd_link_sva #(.RESTART_CYCLES(RESTART)) spd_link_sva_i (.mclk(mclk),
    .rst(rst), .lineA(link.lineA), .lineB(link.lineB),
    .windingsOff(link.windingsOff), .stepSelect(link.stepSelect),
    .resCode(link.resCode), .home(link.home));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic fail_wait;
    nErrors++;
    $display("ERROR %0t wait ran out", $time);
    stop_test();
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int i;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datW <= d;
    sel  <= 4'hF;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) fail_wait();
    rdat = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic move(input logic cw, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if (cw) expPos = (expPos + 1) % expPer;
      else expPos = (expPos == 0) ? expPer - 1 : expPos - 1;
      expQ.push_back({cw, expPos[11:0]});
    end
    wb(1'b1, REG_MOVE, {15'h0000, cw, n[15:0]});
    i = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      i++;
    end while (rdat[0] !== 1'b0 && i < 20000);
    if (rdat[0] !== 1'b0) fail_wait();
    `CHK(rdat[1], expPos == 0)
    repeat (20) @(posedge mclk);
    `CHK(pos2, expPos[11:0])
    `CHK(expQ.size(), 0)
  endtask

  // every accepted microstep is matched to the oldest note
  always @(posedge mclk) begin
    if (microStep === 1'b1) begin
      if (expQ.size() == 0) begin
        nErrors++;
        $display("ERROR %0t step not ordered", $time);
      end else begin
        note = expQ.pop_front();
        `CHK({microCw, pos}, note)
        `CHK(link.home, note[11:0] == 12'h000)
      end
    end
  end

  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, sel, datW} = '0;
    {dialP, dialS, curChk} = '0;
    {modeTwo, modeOne} = 2'b10;
    seed = 32'h13F9;
    expPos = 0;
    expPer = DIV10[0];
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(link.home, 1'b1)
    `CHK(pos, 12'h000)
    `CHK({twoLine, twoLine2}, 2'b10)
    modeTwo <= 1'b0;
    modeOne <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK({twoLine, twoLine2}, 2'b10)
    wb(1'b0, 4'hC, 32'h0);
    `CHK(rdat, 32'h00000000)
    move(1'b1, 10);
    move(1'b0, 3);
    move(1'b1, 3);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (10) @(posedge mclk);
    `CHK(windEn, 1'b0)
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (10) @(posedge mclk);
    `CHK(windEn, 1'b1)
    curChk <= 1'b1;
    repeat (80) @(posedge mclk);
    `CHK(standstill, 1'b0)
    curChk <= 1'b0;
    repeat (80) @(posedge mclk);
    `CHK(standstill, 1'b1)
    wb(1'b1, REG_CTRL, 32'h2);
    for (c = 0; c < 16; c++) begin
      wb(1'b1, REG_CTRL, {24'h000000, c[3:0], 4'h2});
      dialS <= c[3:0];
      repeat (10) @(posedge mclk);
      `CHK(divCode, c[3:0])
      `CHK(divCode2, c[3:0])
    end
    r = $random(seed);
    dialP <= r[3:0];
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (10) @(posedge mclk);
    `CHK(divCode, dialP)
    r = $random(seed);
    c = (r & 1) + 1;
    dialP <= c[3:0];
    wb(1'b1, REG_CTRL, {24'h000000, c[3:0], 4'h0});
    repeat (10) @(posedge mclk);
    `CHK(divCode2, c[3:0])
    expPer = DIV10[c];
    move(1'b1, expPer);
    stop_test();
  end
endmodule
